/* File: auc_pkg.sv */
package auc_pkg;
	localparam int unsigned CLK_HZ          = 40000000;
	localparam int unsigned FIFO_DEPTH      = 3;
	localparam int unsigned BUF_DEPTH       = 4;
	localparam int unsigned CHAR_W          = 8;
	localparam logic [3:0]  OVS_LAST        = 4'hF;
	localparam logic [3:0]  START_CHECK     = 4'h7;
	localparam logic [3:0]  HALF_BIT        = 4'h7;
	localparam logic [1:0]  BREAK_END_EDGES = 2'h2;
	localparam logic [1:0]  LEN5            = 2'h0;
	localparam logic [1:0]  LEN8            = 2'h3;
	localparam logic [1:0]  STOP1           = 2'h0;
	localparam logic [1:0]  STOP15          = 2'h1;
	localparam logic [1:0]  STOP2           = 2'h2;

	typedef struct packed {
		logic       brk;
		logic       frame_err;
		logic       parity_err;
		logic [7:0] data;
	} auc_rx_entry_t;

	typedef struct packed {
		logic [1:0] char_len;
		logic       parity_en;
		logic       parity_odd;
		logic       parity_force;
		logic [1:0] stop_len;
		logic       mode_1x;
		logic       block_err;
		logic       cts_gate;
		logic       rts_tx_ctl;
	} auc_cfg_t;

	typedef struct packed {
		logic tx_enable;
		logic tx_disable;
		logic tx_reset;
		logic brk_start;
		logic brk_stop;
		logic rx_enable;
		logic rx_disable;
		logic rx_reset;
		logic err_reset;
	} auc_cmd_t;
endpackage : auc_pkg

/* File: auc_uart.sv */
// Behaviour
// - Holding-free flag high when enabled and empty; drops on CPU write.
// - Held char moves to idle shifter; holding-free rises again.
// - Writes refused while transmitter is disabled.
// - Frame is start, data LSB first, optional parity, stop length.
// - Idle line high, all-empty set; cleared on new write.
// - Disable lets the current character finish.
// - Break command drives serial output low continuously.
// - Transmitter reset stops at once until re-enabled.
// - With gating, start only while clear-to-send low; finish current.
// - Tx-controlled request-to-send negates one bit after drain when disabled; code negates at the second tx_tick after drain.
// - Start resampled after 7.5 ticks (16X) or next tick (1X).
// - Mid-bit sampling; data LSB first, parity, one stop bit.
// - Character into FIFO, available flag set, upper bits zero.
// - Non-zero char without stop, low half bit later: new start.
// - Error flags latched at character boundary before available flag.
// - Line low whole character loads zero char and break bit.
// - Break ends after line high for two clock edges.
// - Receive FIFO three deep, written into first empty place.
// - Available while non-empty; full flag when three stored.
// - Read returns oldest; popped after the read cycle.
// - Parity, framing, break stored per char; overrun not.
// - Char mode reports head flags; block mode ORs since reset.
// - Full FIFO holds char in shifter; next start discards, sets overrun.
`timescale 1ns/1ps
`default_nettype none
module auc_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic             clk_sys_i,
	input  wire logic             rstn_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o,
	output logic [2:0]            count_o
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [1:0]       rd_ptr;
	logic [1:0]       wr_ptr;
	logic             push;
	logic             pop;
	assign in_ready_o  = count_o < 3'(DEPTH);
	assign out_valid_o = count_o != 3'h0;
	assign out_data_o  = mem[rd_ptr];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	always_ff @(posedge clk_sys_i) begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_ptr  <= 2'h0;
			wr_ptr  <= 2'h0;
			count_o <= 3'h0;
		end else if (flush_i) begin
			rd_ptr  <= 2'h0;
			wr_ptr  <= 2'h0;
			count_o <= 3'h0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == 2'(DEPTH - 1)) ? 2'h0 : wr_ptr + 2'h1;
			if (pop)
				rd_ptr <= (rd_ptr == 2'(DEPTH - 1)) ? 2'h0 : rd_ptr + 2'h1;
			count_o <= count_o + 3'(push) - 3'(pop);
		end
	end
endmodule : auc_fifo

module auc_uart
	import auc_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       rstn_i,
	input  wire logic       bit_tick_i,
	input  wire auc_cfg_t   cfg_i,
	input  wire auc_cmd_t   cmd_i,
	input  wire logic       tx_write_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       rx_read_i,
	input  wire logic       rxd_i,
	input  wire logic       clear_to_send_n_i,
	output logic            txd_o,
	output logic            request_to_send_n_o,
	output logic            tx_holding_free_o,
	output logic            tx_all_empty_o,
	output logic            rx_char_available_o,
	output logic            rx_fifo_full_flag_o,
	output logic [7:0]      rx_data_o,
	output logic [4:0]      channel_status_reg_o
);
	typedef enum {AUC_TX_IDLE, AUC_TX_START, AUC_TX_DATA, AUC_TX_PAR, AUC_TX_STOP, AUC_TX_RTS} auc_tx_st_t;
	typedef enum {AUC_RX_HUNT, AUC_RX_CHECK, AUC_RX_DATA, AUC_RX_PAR, AUC_RX_STOP, AUC_RX_BRK} auc_rx_st_t;

	auc_tx_st_t    tx_st;
	auc_rx_st_t    rx_st;
	logic          tx_en;
	logic          tx_brk;
	logic          hold_full;
	logic [7:0]    hold_data;
	logic [7:0]    tx_shift;
	logic [3:0]    tx_div;
	logic [2:0]    tx_bit;
	logic          tx_par;
	logic          tx_tick;
	logic [4:0]    tx_stop_ticks;
	logic [2:0]    len_last;
	logic          rx_en;
	logic          rxd_q;
	logic [3:0]    rx_div;
	logic [2:0]    rx_bit;
	logic [7:0]    rx_shift;
	logic          rx_par;
	logic          rx_half;
	logic          held_valid;
	auc_rx_entry_t held;
	logic          overrun;
	logic [1:0]    high_edges;
	logic          rx_tick;
	logic          fifo_in_ready;
	logic          fifo_out_valid;
	auc_rx_entry_t fifo_head;
	logic [2:0]    fifo_count;
	logic [2:0]    err_block;
	logic          rts_armed;

	assign len_last = 3'(cfg_i.char_len) + 3'h4;
	// Divide bit clock ticks by 16 unless in 1X mode
	assign tx_tick  = bit_tick_i && (cfg_i.mode_1x || tx_div == OVS_LAST);
	assign rx_tick  = bit_tick_i && (cfg_i.mode_1x || rx_div == OVS_LAST);
	// Index of the last 16X tick of the stop period; two stop bits need all 5 bits
	assign tx_stop_ticks = (cfg_i.stop_len == STOP1) ? 5'h0F : (cfg_i.stop_len == STOP15) ? 5'h17 : 5'h1F;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_en  <= 1'b0;
			tx_brk <= 1'b0;
		end else begin
			if (cmd_i.tx_reset || cmd_i.tx_disable)
				tx_en <= 1'b0;
			else if (cmd_i.tx_enable)
				tx_en <= 1'b1;
			if (cmd_i.tx_reset || cmd_i.brk_stop)
				tx_brk <= 1'b0;
			else if (cmd_i.brk_start)
				tx_brk <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hold_full <= 1'b0;
			hold_data <= 8'h00;
		end else if (cmd_i.tx_reset) begin
			hold_full <= 1'b0;
		end else if (tx_write_i && tx_en && !hold_full) begin
			hold_full <= 1'b1;
			hold_data <= tx_data_i;
		end else if (hold_full && tx_st == AUC_TX_IDLE && !tx_brk && (!cfg_i.cts_gate || !clear_to_send_n_i)) begin
			hold_full <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_st    <= AUC_TX_IDLE;
			tx_shift <= 8'h00;
			tx_div   <= 4'h0;
			tx_bit   <= 3'h0;
			tx_par   <= 1'b0;
			txd_o    <= 1'b1;
		end else if (cmd_i.tx_reset) begin
			tx_st <= AUC_TX_IDLE;
			txd_o <= 1'b1;
		end else begin
			if (bit_tick_i)
				tx_div <= tx_div + 4'h1;
			case (tx_st)
				AUC_TX_IDLE: begin
					if (hold_full && !tx_brk && (!cfg_i.cts_gate || !clear_to_send_n_i)) begin
						tx_st    <= AUC_TX_START;
						tx_shift <= hold_data;
						tx_par   <= cfg_i.parity_odd;
						tx_div   <= 4'h0;
					end
				end
				AUC_TX_START: if (tx_tick) begin
					tx_st  <= AUC_TX_DATA;
					tx_bit <= 3'h0;
				end
				AUC_TX_DATA: if (tx_tick) begin
					tx_par   <= tx_par ^ tx_shift[0];
					tx_shift <= {1'b0, tx_shift[7:1]};
					tx_bit   <= tx_bit + 3'h1;
					if (tx_bit == len_last) begin
						tx_st  <= cfg_i.parity_en ? AUC_TX_PAR : AUC_TX_STOP;
						tx_bit <= 3'h0;
						tx_div <= 4'h0;
					end
				end
				AUC_TX_PAR: if (tx_tick) begin
					tx_st  <= AUC_TX_STOP;
					tx_div <= 4'h0;
				end
				AUC_TX_STOP: if (bit_tick_i) begin
					// Stop length counted in 16ths; 1X mode uses whole bits
					tx_bit <= tx_bit + 3'h1;
					if (cfg_i.mode_1x ? (tx_bit == 3'(cfg_i.stop_len == STOP2)) :
							({tx_bit[0], tx_div} == tx_stop_ticks)) begin
						tx_st  <= AUC_TX_IDLE;
						tx_bit <= 3'h0;
					end else if (!cfg_i.mode_1x && tx_div != OVS_LAST)
						tx_bit <= tx_bit;
				end
				default: tx_st <= AUC_TX_IDLE;
			endcase
			if (tx_brk)
				txd_o <= 1'b0;
			else
				case (tx_st)
					AUC_TX_START: txd_o <= 1'b0;
					AUC_TX_DATA:  txd_o <= tx_shift[0];
					AUC_TX_PAR:   txd_o <= cfg_i.parity_force ? cfg_i.parity_odd : tx_par;
					default:      txd_o <= 1'b1;
				endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_holding_free_o <= 1'b0;
			tx_all_empty_o    <= 1'b0;
		end else begin
			tx_holding_free_o <= tx_en && !hold_full && !(tx_write_i && tx_en);
			tx_all_empty_o    <= tx_en && !hold_full && !tx_write_i && tx_st == AUC_TX_IDLE;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			request_to_send_n_o <= 1'b1;
			rts_armed           <= 1'b0;
			rx_half             <= 1'b0;
		end else begin
			rts_armed <= cfg_i.rts_tx_ctl && !tx_en && !hold_full && tx_st == AUC_TX_IDLE;
			// First tick opens the bit time, the next one closes it
			if (!rts_armed)
				rx_half <= 1'b0;
			else if (tx_tick)
				rx_half <= 1'b1;
			// Enable wins, so a re-enable never sees a stale drop
			if (tx_en)
				request_to_send_n_o <= 1'b0;
			else if (rts_armed && rx_half && tx_tick)
				request_to_send_n_o <= 1'b1;
		end
	end

	// Receiver enable
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i)
			rx_en <= 1'b0;
		else if (cmd_i.rx_reset || cmd_i.rx_disable)
			rx_en <= 1'b0;
		else if (cmd_i.rx_enable)
			rx_en <= 1'b1;
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_st      <= AUC_RX_HUNT;
			rxd_q      <= 1'b1;
			rx_div     <= 4'h0;
			rx_bit     <= 3'h0;
			rx_shift   <= 8'h00;
			rx_par     <= 1'b0;
			high_edges <= 2'h0;
			held_valid <= 1'b0;
			held       <= '0;
			overrun    <= 1'b0;
		end else begin
			rxd_q <= rxd_i;
			if (bit_tick_i)
				rx_div <= rx_div + 4'h1;
			if (held_valid && fifo_in_ready)
				held_valid <= 1'b0;
			if (cmd_i.err_reset || cmd_i.rx_reset)
				overrun <= 1'b0;
			if (!rx_en) begin
				rx_st <= AUC_RX_HUNT;
			end else case (rx_st)
				AUC_RX_HUNT: if (rxd_q && !rxd_i) begin
					rx_st  <= AUC_RX_CHECK;
					rx_div <= 4'h0;
				end
				AUC_RX_CHECK: if (bit_tick_i && (cfg_i.mode_1x || rx_div == START_CHECK)) begin
					rx_st    <= rxd_i ? AUC_RX_HUNT : AUC_RX_DATA;
					rx_div   <= 4'h0;
					rx_bit   <= 3'h0;
					rx_shift <= 8'h00;
					rx_par   <= cfg_i.parity_odd;
					if (!rxd_i && held_valid && !fifo_in_ready) begin
						held_valid <= 1'b0;
						overrun    <= 1'b1;
					end
				end
				AUC_RX_DATA: if (rx_tick) begin
					rx_shift[rx_bit] <= rxd_i;
					rx_par <= rx_par ^ rxd_i;
					rx_bit <= rx_bit + 3'h1;
					if (rx_bit == len_last)
						rx_st <= cfg_i.parity_en ? AUC_RX_PAR : AUC_RX_STOP;
				end
				AUC_RX_PAR: if (rx_tick) begin
					rx_par <= cfg_i.parity_force ? (rxd_i != cfg_i.parity_odd) : (rx_par ^ rxd_i);
					rx_st  <= AUC_RX_STOP;
				end
				AUC_RX_STOP: if (rx_tick) begin
					held_valid      <= 1'b1;
					held.data       <= rx_shift;
					held.frame_err  <= !rxd_i;
					held.parity_err <= cfg_i.parity_en && rx_par;
					held.brk        <= !rxd_i && rx_shift == 8'h00 && !(cfg_i.parity_en && rxd_q);
					rx_div          <= 4'h0;
					if (rxd_i)
						rx_st <= AUC_RX_HUNT;
					else if (rx_shift == 8'h00)
						rx_st <= AUC_RX_BRK;
					else
						// half-bit re-start reuses the check state
						rx_st <= AUC_RX_CHECK;
				end
				// break end after two high edges
				AUC_RX_BRK: begin
					high_edges <= rxd_i ? high_edges + 2'h1 : 2'h0;
					if (rxd_i && high_edges == BREAK_END_EDGES - 2'h1) begin
						rx_st      <= AUC_RX_HUNT;
						high_edges <= 2'h0;
					end
				end
				default: rx_st <= AUC_RX_HUNT;
			endcase
		end
	end

	auc_fifo #(
		.WIDTH ($bits(auc_rx_entry_t)),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk_sys_i   (clk_sys_i),
		.rstn_i      (rstn_i),
		.flush_i     (cmd_i.rx_reset),
		.in_valid_i  (held_valid),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (held),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (rx_read_i),
		.out_data_o  (fifo_head),
		.count_o     (fifo_count)
	);

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_char_available_o  <= 1'b0;
			rx_fifo_full_flag_o  <= 1'b0;
			rx_data_o            <= 8'h00;
			err_block            <= 3'h0;
			channel_status_reg_o <= 5'h00;
		end else begin
			rx_char_available_o <= fifo_out_valid;
			rx_fifo_full_flag_o <= fifo_count == 3'(FIFO_DEPTH);
			rx_data_o           <= fifo_out_valid ? fifo_head.data : 8'h00;
			// Head flags win over a reset-error in the same cycle
			err_block <= (cmd_i.err_reset ? 3'h0 : err_block) |
				(fifo_out_valid ? {fifo_head.brk, fifo_head.frame_err, fifo_head.parity_err} : 3'h0);
			channel_status_reg_o <= {overrun, cfg_i.block_err ? err_block :
				(fifo_out_valid ? {fifo_head.brk, fifo_head.frame_err, fifo_head.parity_err} : 3'h0),
				1'b0};
		end
	end

	cov_tx_frame_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) tx_st == AUC_TX_STOP ##1 tx_st == AUC_TX_IDLE);
	cov_rx_char_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) held_valid && fifo_in_ready);
	cov_fifo_full_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) rx_fifo_full_flag_o);

	tx_refuse_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!tx_en && !hold_full |=> !hold_full) else $error("write accepted while disabled");
	tx_brk_low_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		tx_brk && !cmd_i.tx_reset |=> !txd_o) else $error("break not low");
	tx_reset_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		cmd_i.tx_reset |=> tx_st == AUC_TX_IDLE && !hold_full && !tx_en) else $error("reset did not stop");
	tx_cts_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		tx_st == AUC_TX_IDLE && cfg_i.cts_gate && clear_to_send_n_i |=> tx_st != AUC_TX_START) else $error("start without cts");
	tx_free_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		tx_write_i && tx_en |=> !tx_holding_free_o) else $error("free flag stayed high");
	rx_full_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		fifo_count == 3'h3 |=> rx_fifo_full_flag_o && rx_char_available_o) else $error("full flag missing");
	rx_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		fifo_count <= 3'h3) else $error("fifo over three");
	rx_false_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		rx_en && rx_st == AUC_RX_CHECK && bit_tick_i && (cfg_i.mode_1x || rx_div == START_CHECK) && rxd_i
		|=> rx_st == AUC_RX_HUNT)
		else $error("false start kept");
endmodule : auc_uart
`default_nettype wire

/* File: auc_remote.sv */
`timescale 1ns/1ps
`default_nettype none
module auc_remote
	import auc_pkg::*;
#(
	parameter int BIT_CLKS = 32
) (
	input  wire logic      clk_sys_i,
	input  wire auc_cfg_t  cfg_i,
	input  wire logic      txd_i,
	output var logic       rxd_o,
	output var logic       got_o,
	output var logic [8:0] got_data_o
);
	int         nb;
	logic [7:0] sh;
	logic       pe;

	always_comb nb = 5 + int'(cfg_i.char_len);

	task automatic bit_out(input logic v, input int n);
		rxd_o = v;
		repeat (n) @(negedge clk_sys_i);
	endtask : bit_out

	// Short stop so a bad stop never looks like a new start
	task automatic send(input logic [7:0] d, input logic bad, input logic stp);
		bit_out(1'b0, BIT_CLKS);
		for (int i = 0; i < nb; i++) bit_out(d[i], BIT_CLKS);
		if (cfg_i.parity_en) bit_out(^d ^ cfg_i.parity_odd ^ bad, BIT_CLKS);
		bit_out(stp, BIT_CLKS / 2 + 4);
		bit_out(1'b1, BIT_CLKS * 2);
	endtask : send

	initial begin
		rxd_o = 1'b1;
		got_o = 1'b0;
		got_data_o = '0;
		forever begin
			@(negedge txd_i);
			repeat (BIT_CLKS / 2) @(posedge clk_sys_i);
			if (txd_i === 1'b0) begin
				sh = '0;
				for (int i = 0; i < nb; i++) begin
					repeat (BIT_CLKS) @(posedge clk_sys_i);
					sh[i] = txd_i;
				end
				pe = ^sh ^ cfg_i.parity_odd;
				if (cfg_i.parity_en) begin
					repeat (BIT_CLKS) @(posedge clk_sys_i);
					pe = pe ^ txd_i;
				end else begin
					pe = 1'b0;
				end
				repeat (BIT_CLKS) @(posedge clk_sys_i);
				got_data_o <= {pe | ~txd_i, sh};
				got_o <= 1'b1;
				@(posedge clk_sys_i);
				got_o <= 1'b0;
			end
		end
	end
endmodule : auc_remote
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
	begin \
		num_checks++; \
		if ((g) !== (e)) begin \
			err_total++; \
			$display("MISMATCH %s expected %h seen %h", nm, e, g); \
		end \
	end
module tb
	import auc_pkg::*;
;
	localparam int BIT = 32;
	logic        clk_sys_i, rstn_i, bit_tick_i, tdiv, tx_write_i, rx_read_i;
	logic        rxd_i, clear_to_send_n_i, txd_o, request_to_send_n_o, got;
	logic        tx_holding_free_o, tx_all_empty_o, rx_char_available_o, rx_fifo_full_flag_o;
	auc_cfg_t    cfg_i;
	auc_cmd_t    cmd_i;
	logic [7:0]  tx_data_i, rx_data_o, d;
	logic [4:0]  channel_status_reg_o;
	logic [8:0]  gdata, e9;
	logic [10:0] e11, g11;
	logic [31:0] seed;
	logic [8:0]  exp_tx[$];
	logic [10:0] exp_rx[$];
	int          err_total, num_checks, n;

	auc_uart auc_uart_inst (
		.clk_sys_i, .rstn_i, .bit_tick_i, .cfg_i, .cmd_i, .tx_write_i, .tx_data_i,
		.rx_read_i, .rxd_i, .clear_to_send_n_i, .txd_o, .request_to_send_n_o,
		.tx_holding_free_o, .tx_all_empty_o, .rx_char_available_o, .rx_fifo_full_flag_o,
		.rx_data_o, .channel_status_reg_o
	);
	auc_remote #(.BIT_CLKS(BIT)) auc_remote_inst (
		.clk_sys_i, .cfg_i, .txd_i(txd_o), .rxd_o(rxd_i), .got_o(got), .got_data_o(gdata)
	);

	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	// Sixteen ticks per bit gives 32 clocks per bit
	always @(negedge clk_sys_i) begin
		tdiv <= ~tdiv;
		bit_tick_i <= tdiv;
	end

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd

	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	task automatic do_cmd(input logic [8:0] c);
		cmd_i = c;
		@(negedge clk_sys_i);
		cmd_i = '0;
		@(negedge clk_sys_i);
	endtask : do_cmd

	task automatic wr(input logic [7:0] v, input logic take);
		n = 0;
		while (take && tx_holding_free_o !== 1'b1 && n < 4000) begin
			@(negedge clk_sys_i);
			n++;
		end
		tx_data_i = v;
		tx_write_i = 1'b1;
		@(negedge clk_sys_i);
		tx_write_i = 1'b0;
		if (take) exp_tx.push_back({1'b0, v & (8'hFF >> (LEN8 - cfg_i.char_len))});
	endtask : wr

	task automatic drain();
		n = 0;
		repeat (4) @(negedge clk_sys_i);
		while (tx_all_empty_o !== 1'b1 && n < 8000) begin
			@(negedge clk_sys_i);
			n++;
		end
		repeat (BIT * 2) @(negedge clk_sys_i);
		`CHK("tx_empty", 1'b1, tx_all_empty_o)
		`CHK("txd_idle", 1'b1, txd_o)
	endtask : drain

	task automatic rd();
		n = 0;
		while (rx_char_available_o !== 1'b1 && n < 8000) begin
			@(negedge clk_sys_i);
			n++;
		end
		repeat (2) @(negedge clk_sys_i);
		rx_read_i = 1'b1;
		@(negedge clk_sys_i);
		rx_read_i = 1'b0;
	endtask : rd

	always @(posedge clk_sys_i) begin
		if (got === 1'b1) begin
			`CHK("tx_pending", 1'b1, exp_tx.size() != 0)
			if (exp_tx.size() != 0) begin
				e9 = exp_tx.pop_front();
				`CHK("tx_frame", e9, gdata)
			end
		end
	end

	// Frame flag may accompany a break, so it is not judged there
	always @(posedge clk_sys_i) begin
		if (rx_read_i === 1'b1 && exp_rx.size() != 0) begin
			e11 = exp_rx.pop_front();
			g11 = {channel_status_reg_o[3:1], rx_data_o};
			if (e11[10]) g11[9] = 1'b0;
			`CHK("rx_char", e11, g11)
		end
	end

	initial begin
		repeat (60000) @(posedge clk_sys_i);
		err_total++;
		give_verdict();
	end

	initial begin
		{rstn_i, tdiv, bit_tick_i, tx_write_i, rx_read_i, clear_to_send_n_i} = '0;
		cfg_i = '0;
		cfg_i.char_len = LEN8;
		cmd_i = '0;
		tx_data_i = '0;
		seed = 32'h000179DE;
		err_total = 0;
		num_checks = 0;
		repeat (16) @(negedge clk_sys_i);
		`CHK("txd_rst", 1'b1, txd_o)
		rstn_i = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		wr(rnd(), 1'b0);
		repeat (BIT * 12) @(negedge clk_sys_i);
		`CHK("free_off", 1'b0, tx_holding_free_o)
		do_cmd(9'h108);
		`CHK("free_on", 1'b1, tx_holding_free_o)
		`CHK("rts_on", 1'b0, request_to_send_n_o)
		wr(rnd(), 1'b1);
		wr(rnd(), 1'b1);
		repeat (4) @(negedge clk_sys_i);
		`CHK("free_full", 1'b0, tx_holding_free_o)
		`CHK("not_empty", 1'b0, tx_all_empty_o)
		drain();
		cfg_i = {LEN5, 3'b110, STOP2, 4'h0};
		wr(rnd(), 1'b1);
		wr(rnd(), 1'b1);
		drain();
		cfg_i = {LEN8, 3'b000, STOP1, 4'h2};
		clear_to_send_n_i = 1'b1;
		wr(rnd(), 1'b1);
		n = 0;
		repeat (BIT * 12) begin
			@(negedge clk_sys_i);
			if (txd_o !== 1'b1) n++;
		end
		`CHK("cts_hold", 0, n)
		clear_to_send_n_i = 1'b0;
		drain();
		// reset drops a blocked char and stops the transmitter
		clear_to_send_n_i = 1'b1;
		wr(rnd(), 1'b0);
		do_cmd(9'h040);
		clear_to_send_n_i = 1'b0;
		n = 0;
		repeat (BIT * 12) begin
			@(negedge clk_sys_i);
			if (txd_o !== 1'b1) n++;
		end
		`CHK("rst_quiet", 0, n)
		`CHK("rst_free", 1'b0, tx_holding_free_o)
		do_cmd(9'h100);
		cfg_i.cts_gate = 1'b0;
		cfg_i.rts_tx_ctl = 1'b1;
		wr(rnd(), 1'b1);
		repeat (BIT * 3) @(negedge clk_sys_i);
		do_cmd(9'h080);
		repeat (BIT * 12) @(negedge clk_sys_i);
		`CHK("dis_sent", 0, exp_tx.size())
		`CHK("rts_off", 1'b1, request_to_send_n_o)
		wr(rnd(), 1'b0);
		repeat (BIT * 12) @(negedge clk_sys_i);
		`CHK("free_dis", 1'b0, tx_holding_free_o)
		do_cmd(9'h100);
		exp_tx.push_back(9'h100);
		do_cmd(9'h020);
		repeat (BIT) @(negedge clk_sys_i);
		n = 0;
		repeat (BIT * 13) begin
			@(negedge clk_sys_i);
			if (txd_o !== 1'b0) n++;
		end
		`CHK("brk_low", 0, n)
		do_cmd(9'h010);
		repeat (BIT * 2) @(negedge clk_sys_i);
		// fourth char dropped by fifth start
		for (int i = 0; i < 5; i++) begin
			d = rnd();
			if (i != 3) exp_rx.push_back({3'b000, d});
			auc_remote_inst.send(d, 1'b0, 1'b1);
		end
		`CHK("rx_full", 1'b1, rx_fifo_full_flag_o)
		`CHK("overrun", 1'b1, channel_status_reg_o[4])
		repeat (4) rd();
		repeat (4) @(negedge clk_sys_i);
		`CHK("rx_none", 1'b0, rx_char_available_o)
		cfg_i.parity_en = 1'b1;
		d = rnd() | 8'h01;
		exp_rx.push_back({3'b001, d});
		auc_remote_inst.send(d, 1'b1, 1'b1);
		exp_rx.push_back({3'b010, d});
		auc_remote_inst.send(d, 1'b0, 1'b0);
		rd();
		rd();
		cfg_i = {LEN5, 3'b000, STOP1, 4'h0};
		d = rnd();
		exp_rx.push_back({3'b000, d & 8'h1F});
		auc_remote_inst.send(d, 1'b0, 1'b1);
		rd();
		cfg_i.char_len = LEN8;
		exp_rx.push_back(11'h400);
		auc_remote_inst.bit_out(1'b0, BIT * 12);
		auc_remote_inst.bit_out(1'b1, BIT * 2);
		rd();
		auc_remote_inst.bit_out(1'b0, BIT / 4);
		auc_remote_inst.bit_out(1'b1, BIT * 12);
		`CHK("false_start", 1'b0, rx_char_available_o)
		// block mode keeps an earlier error until reset-error
		do_cmd(9'h001);
		cfg_i.block_err = 1'b1;
		cfg_i.parity_en = 1'b1;
		d = rnd() | 8'h01;
		exp_rx.push_back({3'b001, d});
		auc_remote_inst.send(d, 1'b1, 1'b1);
		rd();
		exp_rx.push_back({3'b001, d});
		auc_remote_inst.send(d, 1'b0, 1'b1);
		rd();
		do_cmd(9'h001);
		`CHK("blk_clr", 3'h0, channel_status_reg_o[3:1])
		`CHK("tx_left", 0, exp_tx.size())
		`CHK("rx_left", 0, exp_rx.size())
		give_verdict();
	end
endmodule : tb
`undef CHK
`default_nettype wire
